//--- src/bcdcal_top.v
// bcd calendar clock with alarm, periodic events and axi4-lite register slave
// Summary of operation
// (RQ1) all time and calendar fields kept as bcd units and tens digits
// (RQ2) software selects 24-hour or 12-hour entry with am/pm bit
// (RQ3) the second divider runs from the 32768 hz reference, never gated
// (RQ4) counters for century 19/20, year, month, date, day, hour, minute, second
// (RQ5) calendar covers years 1900 through 2099
// (RQ6) february has 29 days whenever year is a multiple of four
// (RQ7) seconds advance once per second, carries ripple upward
// (RQ8) software rereads time until two consecutive reads match
// (RQ9) alarm compares month, date, hour, minute, second, each enabled separately
// (RQ10) all enabled alarm fields equal sets alarm flag, interrupt if enabled
// (RQ11) seconds-only alarm fires once per minute
// (RQ12) loads with bad bcd digits or impossible dates are refused
// (RQ13) each time, calendar or alarm word loads as one 32-bit capture
// (RQ14) software-selected periodic event can request an interrupt
// (RQ15) all interrupt causes merge onto one request line
// (RQ16) write protection can block configuration register writes
// (RQ17) refused load keeps old value, sets validity flag until valid write
// (RQ18) software requests time or calendar update before changing fields
// (RQ19) acknowledge flag raised when counting stopped, cleared via status clear
// (RQ20) time update freezes time and calendar; calendar update freezes calendar only
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`include "bcdcal_consts.vh"
module bcdcal_top #(
    parameter REF_PER_SEC = `BCDCAL_REF_HZ // reference edges per second
) (
    input wire aclk, // system clock, 40 mhz
    input wire aresetn, // synchronous reset, active low
    input wire slow_reference_clock, // 32768 hz reference pin
    input wire [7:0] s_axi_awaddr, // write address
    input wire s_axi_awvalid, // write address valid
    output reg s_axi_awready, // write address ready
    input wire [31:0] s_axi_wdata, // write data
    input wire [3:0] s_axi_wstrb, // byte strobes, word taken whole
    input wire s_axi_wvalid, // write data valid
    output reg s_axi_wready, // write data ready
    output reg [1:0] s_axi_bresp, // write response
    output reg s_axi_bvalid, // write response valid
    input wire s_axi_bready, // write response ready
    input wire [7:0] s_axi_araddr, // read address
    input wire s_axi_arvalid, // read address valid
    output reg s_axi_arready, // read address ready
    output reg [31:0] s_axi_rdata, // read data
    output reg [1:0] s_axi_rresp, // read response
    output reg s_axi_rvalid, // read data valid
    input wire s_axi_rready, // read data ready
    output reg irq_reg // interrupt request, active high
);
    reg ref_s1_reg, ref_s2_reg, ref_s3_reg;
    reg [15:0] div_reg;
    reg sec_tick_reg;
    reg time_update_request, calendar_update_request;
    reg [1:0] timevsel_reg, calevsel_reg;
    reg hrmod_reg, wpen_reg, upd_prev_reg;
    reg [31:0] talr_reg, calalr_reg;
    reg [4:0] sr_reg, imr_reg;
    reg [3:0] ver_reg;
    reg aw_full_reg, w_full_reg;
    reg [7:0] awaddr_hold_reg;
    reg [31:0] wdata_hold_reg;
    reg [31:0] rd_mux;
    reg rd_hit;
    reg [4:0] sr_set;
    wire time_ok, cal_ok, talr_ok, calalr_ok;
    wire [5:0] hour24;
    wire [6:0] sec_v, min_v, cent_v;
    wire [5:0] hour_v, date_v;
    wire [7:0] year_v;
    wire [4:0] month_v;
    wire [2:0] day_v;
    wire tick_done, min_ev, hour_ev, day_ev, mon_ev, year_ev;
    // alarm words keep only fields and enables; am/pm is folded into the hour
    localparam [31:0] TALR_KEEP = 32'h00bfffff;
    localparam [31:0] CALALR_KEEP = 32'hbf9f0000;

    // (RQ3) reference edge drives the second divider, no gating input exists
    always @(posedge aclk) begin
        if (!aresetn) begin
            {ref_s1_reg, ref_s2_reg, ref_s3_reg} <= 3'b000;
            div_reg <= 16'h0000;
            sec_tick_reg <= 1'b0;
        end else begin
            // two flops tame the pin, the third only marks its rising edge
            ref_s1_reg <= slow_reference_clock;
            ref_s2_reg <= ref_s1_reg;
            ref_s3_reg <= ref_s2_reg;
            sec_tick_reg <= 1'b0;
            if (ref_s2_reg && !ref_s3_reg) begin
                // limitation: sixteen bits, so at most 65536 edges per second
                if (div_reg == REF_PER_SEC[15:0] - 16'h0001) begin
                    div_reg <= 16'h0000;
                    sec_tick_reg <= 1'b1;
                end else begin
                    div_reg <= div_reg + 16'h0001;
                end
            end
        end
    end

    // a write executes once both halves are held and the last answer is gone
    wire wr_go = aw_full_reg && w_full_reg && !s_axi_bvalid;
    wire [7:0] wa = awaddr_hold_reg;
    wire [31:0] wd = wdata_hold_reg;
    // (RQ12) entry checking of the captured word
    bcdcal_check u_check (
        .wdata(wd),
        .hrmod(hrmod_reg),
        .time_ok(time_ok),
        .cal_ok(cal_ok),
        .talr_ok(talr_ok),
        .calalr_ok(calalr_ok),
        .hour24(hour24)
    );
    // (RQ13) whole-word capture, only while the matching update is requested
    wire load_time = wr_go && wa == `BCDCAL_OFF_TIMR && time_update_request && time_ok;
    wire load_cal = wr_go && wa == `BCDCAL_OFF_CALR && calendar_update_request && cal_ok;
    wire cfg_ok = !wpen_reg;

    // counters keep 24-hour time; 12-hour entries are converted on the way in
    bcdcal_counter u_counter (
        .aclk(aclk),
        .aresetn(aresetn),
        .sec_tick(sec_tick_reg),
        // (RQ20) time request stops both, calendar request only the calendar
        .time_run(!time_update_request),
        .cal_run(!time_update_request && !calendar_update_request),
        .load_time(load_time),
        .time_in({hour24, wd[14:8], wd[6:0]}),
        .load_cal(load_cal),
        .cal_in({wd[29:8], wd[6:0]}),
        .sec_reg(sec_v),
        .min_reg(min_v),
        .hour_reg(hour_v),
        .cent_reg(cent_v),
        .year_reg(year_v),
        .month_reg(month_v),
        .day_reg(day_v),
        .date_reg(date_v),
        .tick_done_reg(tick_done),
        .min_ev_reg(min_ev),
        .hour_ev_reg(hour_ev),
        .day_ev_reg(day_ev),
        .mon_ev_reg(mon_ev),
        .year_ev_reg(year_ev)
    );

    // with no field enabled nothing matches, rather than every second
    // (RQ9) only enabled fields take part
    wire alr_any = talr_reg[`BCDCAL_ALR_SECEN] || talr_reg[`BCDCAL_ALR_MINEN] ||
        talr_reg[`BCDCAL_ALR_HOUREN] || calalr_reg[`BCDCAL_ALR_MTHEN] || calalr_reg[`BCDCAL_ALR_DATEEN];
    wire alr_match = alr_any &&
        (!talr_reg[`BCDCAL_ALR_SECEN] || talr_reg[6:0] == sec_v) &&
        (!talr_reg[`BCDCAL_ALR_MINEN] || talr_reg[14:8] == min_v) &&
        (!talr_reg[`BCDCAL_ALR_HOUREN] || talr_reg[21:16] == hour_v) &&
        (!calalr_reg[`BCDCAL_ALR_MTHEN] || calalr_reg[20:16] == month_v) &&
        (!calalr_reg[`BCDCAL_ALR_DATEEN] || calalr_reg[29:24] == date_v);

    always @* begin
        sr_set = 5'h00;
        // counting is frozen from the edge the request is stored, so no wait
        // (RQ19) acknowledge once counting has stopped
        sr_set[`BCDCAL_SR_UPDATE_ACKNOWLEDGE_FLAG] = (time_update_request || calendar_update_request) && !upd_prev_reg;
        // (RQ10) (RQ11) checked once each time the seconds move
        sr_set[`BCDCAL_SR_ALARM] = tick_done && alr_match;
        sr_set[`BCDCAL_SR_SEC] = sec_tick_reg;
        // (RQ14) periodic event selection
        case (timevsel_reg)
            2'd0: sr_set[`BCDCAL_SR_TIMEV] = min_ev;
            2'd1: sr_set[`BCDCAL_SR_TIMEV] = hour_ev;
            2'd2: sr_set[`BCDCAL_SR_TIMEV] = hour_ev && hour_v == 6'h00;
            default: sr_set[`BCDCAL_SR_TIMEV] = hour_ev && hour_v == 6'h12;
        endcase
        case (calevsel_reg)
            2'd0: sr_set[`BCDCAL_SR_CALEV] = day_ev && day_v == 3'h1;
            2'd1: sr_set[`BCDCAL_SR_CALEV] = mon_ev;
            2'd2: sr_set[`BCDCAL_SR_CALEV] = year_ev;
            default: sr_set[`BCDCAL_SR_CALEV] = 1'b0;
        endcase
    end

    always @* begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `BCDCAL_OFF_CR: rd_mux = {14'h0, calevsel_reg, 6'h0, timevsel_reg, 6'h0,
                calendar_update_request, time_update_request};
            `BCDCAL_OFF_MR: rd_mux = {31'h0, hrmod_reg};
            // (RQ1) (RQ4) (RQ8) live counters, software compares two reads
            `BCDCAL_OFF_TIMR: rd_mux = {10'h0, hour_v, 1'b0, min_v, 1'b0, sec_v};
            `BCDCAL_OFF_CALR: rd_mux = {2'h0, date_v, day_v, month_v, year_v, 1'b0, cent_v};
            `BCDCAL_OFF_TALR: rd_mux = talr_reg;
            `BCDCAL_OFF_CALALR: rd_mux = calalr_reg;
            `BCDCAL_OFF_SR: rd_mux = {27'h0, sr_reg};
            `BCDCAL_OFF_IMR: rd_mux = {27'h0, imr_reg};
            `BCDCAL_OFF_VER: rd_mux = {28'h0, ver_reg};
            `BCDCAL_OFF_WPMR: rd_mux = {31'h0, wpen_reg};
            // write-only registers read back as zero
            `BCDCAL_OFF_SCCR, `BCDCAL_OFF_IER, `BCDCAL_OFF_IDR: rd_mux = 32'h0;
            default: begin
                rd_mux = 32'h0;
                rd_hit = 1'b0;
            end
        endcase
    end

    // misaligned offsets answer as unmapped, as reads already do
    wire wr_aligned = wa[1:0] == 2'b00;
    wire wr_hit = wr_aligned && (wa <= `BCDCAL_OFF_VER || wa == `BCDCAL_OFF_WPMR);
    always @(posedge aclk) begin
        if (!aresetn) begin
            {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid} <= 5'h00;
            s_axi_bresp <= `BCDCAL_RESP_OKAY;
            s_axi_rresp <= `BCDCAL_RESP_OKAY;
            s_axi_rdata <= 32'h0;
            {aw_full_reg, w_full_reg} <= 2'b00;
            awaddr_hold_reg <= 8'h00;
            wdata_hold_reg <= 32'h0;
            {time_update_request, calendar_update_request, hrmod_reg, wpen_reg, upd_prev_reg} <= 5'h00;
            timevsel_reg <= 2'd0;
            calevsel_reg <= 2'd0;
            talr_reg <= 32'h0;
            calalr_reg <= `BCDCAL_RST_CALALR;
            sr_reg <= 5'h00;
            imr_reg <= 5'h00;
            ver_reg <= 4'h0;
            irq_reg <= 1'b0;
        end else begin
            upd_prev_reg <= time_update_request || calendar_update_request;
            // level output, one cycle behind the status bits
            // (RQ15) single merged request line
            irq_reg <= |(sr_reg & imr_reg);
            // write channels taken in either order
            s_axi_awready <= !aw_full_reg && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_full_reg && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_reg <= 1'b1;
                awaddr_hold_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_reg <= 1'b1;
                wdata_hold_reg <= s_axi_wdata;
            end
            // set wins over a same-cycle clear
            sr_reg <= (sr_reg & ~((wr_go && wa == `BCDCAL_OFF_SCCR) ? wd[4:0] : 5'h00)) | sr_set;
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                // refused writes still answer okay; only unmapped ones report an error
                s_axi_bresp <= wr_hit ? `BCDCAL_RESP_OKAY : `BCDCAL_RESP_SLVERR;
                case (wa)
                    // (RQ16) protected configuration registers
                    `BCDCAL_OFF_CR: if (cfg_ok) begin
                        // clearing a request lets counting resume at the next tick
                        // (RQ18) update requests from software
                        time_update_request <= wd[0];
                        calendar_update_request <= wd[1];
                        timevsel_reg <= wd[9:8];
                        calevsel_reg <= wd[17:16];
                    end
                    // (RQ2) 12/24-hour selection
                    `BCDCAL_OFF_MR: if (cfg_ok) begin
                        hrmod_reg <= wd[0];
                    end
                    // outside an update request a time or calendar write changes nothing
                    // (RQ17) refused word keeps old value, flag until a good write
                    `BCDCAL_OFF_TIMR: if (time_update_request) begin
                        ver_reg[`BCDCAL_VER_TIM] <= !time_ok;
                    end
                    `BCDCAL_OFF_CALR: if (calendar_update_request) begin
                        ver_reg[`BCDCAL_VER_CAL] <= !cal_ok;
                    end
                    `BCDCAL_OFF_TALR: if (cfg_ok) begin
                        ver_reg[`BCDCAL_VER_TALR] <= !talr_ok;
                        if (talr_ok) begin
                            talr_reg <= {wd[31:23], 1'b0, hour24, wd[15:0]} & TALR_KEEP;
                        end
                    end
                    `BCDCAL_OFF_CALALR: if (cfg_ok) begin
                        ver_reg[`BCDCAL_VER_CALALR] <= !calalr_ok;
                        if (calalr_ok) begin
                            calalr_reg <= wd & CALALR_KEEP;
                        end
                    end
                    `BCDCAL_OFF_IER: imr_reg <= imr_reg | wd[4:0];
                    `BCDCAL_OFF_IDR: imr_reg <= imr_reg & ~wd[4:0];
                    `BCDCAL_OFF_WPMR: wpen_reg <= wd[0];
                    default: ;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
            end
            // read answers one cycle after the address is taken
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_hit ? `BCDCAL_RESP_OKAY : `BCDCAL_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

//--- src/bcdcal_consts.vh
// register map, field positions and reset values of the calendar clock
`ifndef BCDCAL_CONSTS_VH
`define BCDCAL_CONSTS_VH
`define BCDCAL_OFF_CR 8'h00
`define BCDCAL_OFF_MR 8'h04
`define BCDCAL_OFF_TIMR 8'h08
`define BCDCAL_OFF_CALR 8'h0c
`define BCDCAL_OFF_TALR 8'h10
`define BCDCAL_OFF_CALALR 8'h14
`define BCDCAL_OFF_SR 8'h18
`define BCDCAL_OFF_SCCR 8'h1c
`define BCDCAL_OFF_IER 8'h20
`define BCDCAL_OFF_IDR 8'h24
`define BCDCAL_OFF_IMR 8'h28
`define BCDCAL_OFF_VER 8'h2c
`define BCDCAL_OFF_WPMR 8'he4
`define BCDCAL_RST_CALR 32'h01210720
`define BCDCAL_RST_CALALR 32'h01010000
`define BCDCAL_SR_UPDATE_ACKNOWLEDGE_FLAG 0
`define BCDCAL_SR_ALARM 1
`define BCDCAL_SR_SEC 2
`define BCDCAL_SR_TIMEV 3
`define BCDCAL_SR_CALEV 4
`define BCDCAL_VER_TIM 0
`define BCDCAL_VER_CAL 1
`define BCDCAL_VER_TALR 2
`define BCDCAL_VER_CALALR 3
`define BCDCAL_ALR_SECEN 7
`define BCDCAL_ALR_MINEN 15
`define BCDCAL_ALR_HOUREN 23
`define BCDCAL_ALR_MTHEN 23
`define BCDCAL_ALR_DATEEN 31
`define BCDCAL_AMPM_BIT 22
`define BCDCAL_REF_HZ 32768
`define BCDCAL_RESP_OKAY 2'b00
`define BCDCAL_RESP_SLVERR 2'b10
`endif

//--- src/bcdcal_check.v
// entry checking of time, calendar and alarm words, 12-hour to 24-hour conversion
`include "bcdcal_consts.vh"
module bcdcal_check (
    input wire [31:0] wdata, // candidate bus word
    input wire hrmod, // 1: 12-hour entry
    output reg time_ok, // word valid as time
    output reg cal_ok, // word valid as calendar
    output reg talr_ok, // word valid as time alarm
    output reg calalr_ok, // word valid as calendar alarm
    output reg [5:0] hour24 // hour field in 24-hour bcd
);
    function bcd_in;
        input [7:0] v;
        input [7:0] lo;
        input [7:0] hi;
        bcd_in = (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) && (v >= lo) && (v <= hi);
    endfunction
    function [7:0] last_date;
        input [4:0] m;
        input leap;
        case (m)
            5'h02: last_date = leap ? 8'h29 : 8'h28;
            5'h04, 5'h06, 5'h09, 5'h11: last_date = 8'h30;
            default: last_date = 8'h31;
        endcase
    endfunction
    function hour_ok;
        input [5:0] h;
        input ampm;
        input mode12;
        hour_ok = mode12 ? bcd_in({2'b00, h}, 8'h01, 8'h12) : (bcd_in({2'b00, h}, 8'h00, 8'h23) && !ampm);
    endfunction
    reg [7:0] yr;
    reg leap;
    always @* begin
        yr = wdata[15:8];
        // every fourth year leap, no century exception
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) :
            (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
        if (!hrmod) begin
            hour24 = wdata[21:16];
        end else if (wdata[21:16] == 6'h12) begin
            hour24 = wdata[`BCDCAL_AMPM_BIT] ? 6'h12 : 6'h00;
        end else if (!wdata[`BCDCAL_AMPM_BIT]) begin
            hour24 = wdata[21:16];
        end else if (wdata[19:16] >= 4'h8) begin
            hour24 = {wdata[21:20] + 2'h2, wdata[19:16] - 4'h8};
        end else begin
            hour24 = {wdata[21:20] + 2'h1, wdata[19:16] + 4'h2};
        end
        time_ok = bcd_in({1'b0, wdata[6:0]}, 8'h00, 8'h59) && bcd_in({1'b0, wdata[14:8]}, 8'h00, 8'h59) &&
            hour_ok(wdata[21:16], wdata[`BCDCAL_AMPM_BIT], hrmod);
        cal_ok = (wdata[6:0] == 7'h19 || wdata[6:0] == 7'h20) && bcd_in(yr, 8'h00, 8'h99) &&
            bcd_in({3'b000, wdata[20:16]}, 8'h01, 8'h12) && bcd_in({5'b0, wdata[23:21]}, 8'h01, 8'h07) &&
            bcd_in({2'b00, wdata[29:24]}, 8'h01, last_date(wdata[20:16], leap));
        talr_ok = (!wdata[`BCDCAL_ALR_SECEN] || bcd_in({1'b0, wdata[6:0]}, 8'h00, 8'h59)) &&
            (!wdata[`BCDCAL_ALR_MINEN] || bcd_in({1'b0, wdata[14:8]}, 8'h00, 8'h59)) &&
            (!wdata[`BCDCAL_ALR_HOUREN] || hour_ok(wdata[21:16], wdata[`BCDCAL_AMPM_BIT], hrmod));
        // alarm date may be 29 in february since the year is unknown
        calalr_ok = (!wdata[`BCDCAL_ALR_MTHEN] || bcd_in({3'b000, wdata[20:16]}, 8'h01, 8'h12)) &&
            (!wdata[`BCDCAL_ALR_DATEEN] || bcd_in({2'b00, wdata[29:24]}, 8'h01,
            wdata[`BCDCAL_ALR_MTHEN] ? last_date(wdata[20:16], 1'b1) : 8'h31));
    end
endmodule

//--- src/bcdcal_counter.v
// bcd time and calendar counters with carry chain and change pulses
`include "bcdcal_consts.vh"
module bcdcal_counter (
    input wire aclk, // system clock
    input wire aresetn, // synchronous reset, active low
    input wire sec_tick, // one pulse per second
    input wire time_run, // time counting enabled
    input wire cal_run, // calendar counting enabled
    input wire load_time, // capture time_in
    input wire [19:0] time_in, // hour, minute, second
    input wire load_cal, // capture cal_in
    input wire [28:0] cal_in, // date, day, month, year, century
    output reg [6:0] sec_reg, // seconds
    output reg [6:0] min_reg, // minutes
    output reg [5:0] hour_reg, // hours, 24-hour
    output reg [6:0] cent_reg, // century
    output reg [7:0] year_reg, // year
    output reg [4:0] month_reg, // month
    output reg [2:0] day_reg, // day of week
    output reg [5:0] date_reg, // date
    output reg tick_done_reg, // time advanced this cycle
    output reg min_ev_reg, // minute changed
    output reg hour_ev_reg, // hour changed
    output reg day_ev_reg, // day changed
    output reg mon_ev_reg, // month changed
    output reg year_ev_reg // year changed
);
    function [7:0] bcd_inc;
        input [7:0] v;
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction
    wire [7:0] sec_i = bcd_inc({1'b0, sec_reg});
    wire [7:0] min_i = bcd_inc({1'b0, min_reg});
    wire [7:0] hour_i = bcd_inc({2'b00, hour_reg});
    wire [7:0] year_i = bcd_inc(year_reg);
    wire [7:0] month_i = bcd_inc({3'b000, month_reg});
    wire [7:0] date_i = bcd_inc({2'b00, date_reg});
    wire leap = year_reg[4] ? (year_reg[3:0] == 4'h2 || year_reg[3:0] == 4'h6) :
        (year_reg[3:0] == 4'h0 || year_reg[3:0] == 4'h4 || year_reg[3:0] == 4'h8);
    localparam [31:0] RST_CALR = `BCDCAL_RST_CALR;
    reg [5:0] last;
    always @* begin
        // (RQ6) leap every fourth year
        case (month_reg)
            5'h02: last = leap ? 6'h29 : 6'h28;
            5'h04, 5'h06, 5'h09, 5'h11: last = 6'h30;
            default: last = 6'h31;
        endcase
    end
    always @(posedge aclk) begin
        if (!aresetn) begin
            sec_reg <= 7'h00;
            min_reg <= 7'h00;
            hour_reg <= 6'h00;
            {date_reg, day_reg, month_reg, year_reg} <= RST_CALR[29:8];
            cent_reg <= RST_CALR[6:0];
            {tick_done_reg, min_ev_reg, hour_ev_reg, day_ev_reg, mon_ev_reg, year_ev_reg} <= 6'h00;
        end else begin
            {min_ev_reg, hour_ev_reg, day_ev_reg, mon_ev_reg, year_ev_reg} <= 5'h00;
            tick_done_reg <= sec_tick && time_run;
            if (load_time) begin
                {hour_reg, min_reg, sec_reg} <= time_in;
            end
            if (load_cal) begin
                {date_reg, day_reg, month_reg, year_reg, cent_reg} <= cal_in;
            end
            // (RQ7) ripple carry per second
            if (sec_tick && time_run && !load_time) begin
                sec_reg <= (sec_reg == 7'h59) ? 7'h00 : sec_i[6:0];
                if (sec_reg == 7'h59) begin
                    min_ev_reg <= 1'b1;
                    min_reg <= (min_reg == 7'h59) ? 7'h00 : min_i[6:0];
                    if (min_reg == 7'h59) begin
                        hour_ev_reg <= 1'b1;
                        hour_reg <= (hour_reg == 6'h23) ? 6'h00 : hour_i[5:0];
                        // (RQ20) day carry lost while calendar frozen
                        if (hour_reg == 6'h23 && cal_run && !load_cal) begin
                            day_ev_reg <= 1'b1;
                            day_reg <= (day_reg == 3'h7) ? 3'h1 : day_reg + 3'h1;
                            date_reg <= (date_reg == last) ? 6'h01 : date_i[5:0];
                            if (date_reg == last) begin
                                mon_ev_reg <= 1'b1;
                                month_reg <= (month_reg == 5'h12) ? 5'h01 : month_i[4:0];
                                if (month_reg == 5'h12) begin
                                    year_ev_reg <= 1'b1;
                                    year_reg <= (year_reg == 8'h99) ? 8'h00 : year_i;
                                    // (RQ5) 1900..2099, century 19 or 20
                                    if (year_reg == 8'h99) begin
                                        cent_reg <= (cent_reg == 7'h19) ? 7'h20 : 7'h19;
                                    end
                                end
                            end
                        end
                    end
                end
            end
        end
    end
endmodule

//--- tb/bcdcal_top_sva.sv
// bus handshake checks for the calendar clock
module bcdcal_sva (
    input wire aclk, // clock
    input wire aresetn, // reset
    input wire s_axi_awvalid, // aw valid
    input wire s_axi_awready, // aw ready
    input wire s_axi_wvalid, // w valid
    input wire s_axi_wready, // w ready
    input wire s_axi_bvalid, // b valid
    input wire s_axi_bready, // b ready
    input wire s_axi_arvalid, // ar valid
    input wire s_axi_arready, // ar ready
    input wire s_axi_rvalid, // r valid
    input wire s_axi_rready // r ready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire ar = s_axi_arvalid && s_axi_arready;
    wire aw = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    AST_RD_NEXT: assert property (ar |=> s_axi_rvalid) else $error("read late");
    AST_RD_BUSY: assert property (ar |=> (!s_axi_arready) [*2]) else $error("ar early");
    AST_RD_CAUSE: assert property ($rose(s_axi_rvalid) |-> $past(ar)) else $error("stray read");
    AST_RD_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("r stuck");
    AST_WR_ANSWER: assert property (aw |-> ##2 s_axi_bvalid) else $error("write late");
    AST_WR_BUSY: assert property (aw |=> (!s_axi_awready && !s_axi_wready) [*3]) else $error("w early");
    AST_WR_CAUSE: assert property ($rose(s_axi_bvalid) |-> $past(aw, 2)) else $error("stray b");
    AST_WR_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("b stuck");
endmodule
bind bcdcal_top bcdcal_sva u_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready);

//--- tb/bcdcal_top_tb.sv
// register bench for the calendar clock
module bcdcal_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic aclk = 1'h0, aresetn = 1'h0, sref = 1'h0, awv = 1'h0, wv = 1'h0, bre = 1'h0, arv = 1'h0, rre = 1'h0;
    logic [7:0] awa = 8'h0, ara = 8'h0;
    logic [31:0] wd = 32'h0;
    wire awr, wrd, bv, arr, rv, irq;
    wire [1:0] brs, rrs;
    wire [31:0] rdt;
    int fail_count = 0, num_checks = 0, n;
    // four edges a second keeps midnight rollover short
    bcdcal_top #(.REF_PER_SEC(4)) dut (.aclk(aclk), .aresetn(aresetn), .slow_reference_clock(sref),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(brs), .s_axi_bvalid(bv), .s_axi_bready(bre),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rrs),
        .s_axi_rvalid(rv), .s_axi_rready(rre), .irq_reg(irq));
    initial forever #12.5 aclk = ~aclk;
    initial forever begin
        repeat (4) @(posedge aclk);
        sref <= ~sref;
    end
    task automatic finish_test;
        if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic hung;
        fail_count++;
        finish_test();
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) fail_count++;
        if (s !== e) $display("[ERR] %0t seen=%h exp=%h", $time, s, e);
    endtask
    task automatic rw(input [7:0] a, input [31:0] d, input rd = 1'h0, input [31:0] m = 32'hffffffff);
        @(posedge aclk);
        if (rd) {ara, arv, rre} <= {a, 2'h3};
        else {awa, wd, awv, wv, bre} <= {a, d, 3'h7};
        for (n = 0; bv !== 1'h1 && rv !== 1'h1; n++) begin
            if (n == 60) hung();
            @(posedge aclk);
            if (awr === 1'h1) awv <= 1'h0;
            if (wrd === 1'h1) wv <= 1'h0;
            if (arr === 1'h1) arv <= 1'h0;
        end
        {bre, rre} <= 2'h0;
        if (rd) chk(rdt & m, d);
    endtask
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        rw(8'h30, 32'h0, 1'h1);
        chk({30'h0, rrs}, 32'h2);
        rw(8'h00, 32'h3);
        rw(8'h18, 32'h1, 1'h1, 32'h1);
        rw(8'h1c, 32'h1);
        rw(8'h0c, 32'h30220720);
        rw(8'h2c, 32'h2, 1'h1);
        rw(8'h0c, 32'h01210720, 1'h1);
        rw(8'h08, 32'h00235958);
        rw(8'h0c, 32'h29220820);
        rw(8'h2c, 32'h0, 1'h1);
        rw(8'h10, 32'h80);
        rw(8'h20, 32'h2);
        rw(8'h00, 32'h0);
        for (n = 0; irq !== 1'h1; n++) begin
            if (n == 400) hung();
            @(posedge aclk);
        end
        rw(8'h18, 32'ha, 1'h1, 32'hb);
        rw(8'h08, 32'h0, 1'h1);
        rw(8'h0c, 32'h01430820, 1'h1);
        rw(8'h10, 32'h8a);
        chk({30'h0, brs}, 32'h0);
        rw(8'h2c, 32'h4, 1'h1);
        rw(8'h04, 32'h1);
        rw(8'h00, 32'h1);
        rw(8'h08, 32'h00480000);
        rw(8'h08, 32'h00200000, 1'h1);
        rw(8'he4, 32'h1);
        rw(8'h04, 32'h0);
        rw(8'h04, 32'h1, 1'h1);
        rw(8'h24, 32'h2);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        finish_test();
    end
endmodule
